//--- gp_timer_pkg.sv
// package: register map, field layouts and carriers for the 64-bit timer core
package gp_timer_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 64;
  localparam int HALF_W = 32;
  localparam int SYNC_W = 3;
  localparam int N_PINS = 2;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] GLOBAL_CONTROL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] TIMER_CONTROL_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] COUNT_LOW_OFS      = 8'h08;
  localparam logic [ADDR_W-1:0] COUNT_HIGH_OFS     = 8'h0c;
  localparam logic [ADDR_W-1:0] PERIOD_LOW_OFS     = 8'h10;
  localparam logic [ADDR_W-1:0] PERIOD_HIGH_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] RELOAD_LOW_OFS     = 8'h18;
  localparam logic [ADDR_W-1:0] RELOAD_HIGH_OFS    = 8'h1c;

  // ---------------------------------------------------------------
  // field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_64        = 2'h0;
  localparam logic [1:0] MODE_UNCHAINED = 2'h1;
  localparam logic [1:0] MODE_CHAINED   = 2'h3;
  localparam logic [1:0] ENA_OFF        = 2'h0;
  localparam logic [1:0] ENA_ONCE       = 2'h1;
  localparam logic [1:0] ENA_CONT       = 2'h2;
  localparam logic [1:0] ENA_RELOAD     = 2'h3;

  localparam logic [CNT_W-1:0]  CNT_ONE   = 64'h1;
  localparam logic [HALF_W-1:0] HALF_ONE  = 32'h1;
  localparam logic [HALF_W-1:0] HALF_ZERO = 32'h0;

  // ---------------------------------------------------------------
  // register layouts (first member is the top bit)
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       extended_feature_enable;
    logic [1:0] counter_config_select;
    logic       high_half_run;
    logic       low_half_run;
  } global_control_s;

  typedef struct packed {
    logic       high_clock_select;
    logic [1:0] high_enable_select;
    logic       low_clock_select;
    logic [1:0] low_enable_select;
  } timer_control_s;

  localparam int GCR_W = $bits(global_control_s);
  localparam int TCR_W = $bits(timer_control_s);
  localparam global_control_s GCR_RESET = '0;
  localparam timer_control_s  TCR_RESET = '0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic             adv;
    logic             wrap;
    logic             hit;
    logic [CNT_W-1:0] nxt;
  } step_s;

endpackage

//--- gp_timer_64bit_core.sv
// design: 64-bit up-counting timer core with apb register access
`timescale 1ns/1ps

module gp_timer_64bit_core
  import gp_timer_pkg::*;
(
  input  logic              i_clk,
  input  logic              i_rst,
  input  logic              i_ce,
  input  apb_req_s          i_apb,
  input  logic              i_low_ext_input,
  input  logic              i_high_ext_input,
  output logic [DATA_W-1:0] o_prdata,
  output logic              o_pready,
  output logic              o_pslverr,
  output logic              o_timer_match_irq,
  output logic              o_timer_match_dma_event
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  global_control_s   gcr_ff;
  global_control_s   nxt_gcr;
  timer_control_s    tcr_ff;
  timer_control_s    nxt_tcr;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  nxt_cnt;
  logic [CNT_W-1:0]  prd_ff;
  logic [CNT_W-1:0]  nxt_prd;
  logic [CNT_W-1:0]  rel_ff;
  logic [CNT_W-1:0]  nxt_rel;
  logic [HALF_W-1:0] shadow_ff;
  logic [HALF_W-1:0] nxt_shadow;
  logic [DATA_W-1:0] prdata_ff;
  logic [DATA_W-1:0] nxt_prdata;
  logic              pready_ff;
  logic              nxt_pready;
  logic              pslverr_ff;
  logic              nxt_pslverr;
  logic              irq_ff;
  logic              nxt_irq;
  logic [SYNC_W-1:0] sync_ff  [N_PINS];
  logic [SYNC_W-1:0] nxt_sync [N_PINS];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [N_PINS-1:0] ext_pin;
  logic [N_PINS-1:0] edge_det;
  logic [1:0]        mode;
  logic [1:0]        ena_lo;
  logic [1:0]        ena_hi;
  logic              is64;
  logic              unch;
  logic              chained;
  logic              run_lo;
  logic              run_hi;
  logic              run_all;
  logic              tick_lo;
  logic              tick_hi;
  logic              pre_hit;
  logic [HALF_W-1:0] pre_nxt;
  logic [HALF_W-1:0] cnt_lo;
  logic [HALF_W-1:0] cnt_hi;
  logic [HALF_W-1:0] prd_lo;
  logic [HALF_W-1:0] prd_hi;
  logic              ok_lo;
  logic              ok_hi;
  logic              acc;
  logic              rd_cap;
  logic              wr_done;
  logic              addr_hit;
  step_s             s64;
  step_s             slo;
  step_s             shi;
  logic              rld_lo;
  logic              rld_hi;

  assign ext_pin = {i_high_ext_input, i_low_ext_input};
  assign mode    = gcr_ff.counter_config_select;
  assign is64    = (mode == MODE_64);
  assign unch    = (mode == MODE_UNCHAINED);
  assign chained = (mode == MODE_CHAINED);
  assign run_lo  = gcr_ff.low_half_run;
  assign run_hi  = gcr_ff.high_half_run;
  assign run_all = run_lo && run_hi;
  assign ena_lo  = tcr_ff.low_enable_select;
  assign ena_hi  = unch ? tcr_ff.high_enable_select : ena_lo;
  assign cnt_lo  = cnt_ff[HALF_W-1:0];
  assign cnt_hi  = cnt_ff[CNT_W-1:HALF_W];
  assign prd_lo  = prd_ff[HALF_W-1:0];
  assign prd_hi  = prd_ff[CNT_W-1:HALF_W];

  // ---------------------------------------------------------------
  // input pin synchronisers and edge detect
  // ---------------------------------------------------------------
  for (genvar k = 0; k < N_PINS; k++) begin : g_sync
    always_comb begin
      nxt_sync[k] = {sync_ff[k][SYNC_W-2:0], ext_pin[k]};
    end
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        sync_ff[k] <= '0;
      end else if (i_ce) begin
        sync_ff[k] <= nxt_sync[k];
      end
    end
    assign edge_det[k] = sync_ff[k][SYNC_W-2] & ~sync_ff[k][SYNC_W-1];
  end

  // ---------------------------------------------------------------
  // clock source selection
  // ---------------------------------------------------------------
  assign tick_lo = tcr_ff.low_clock_select ? edge_det[0] : 1'b1;
  assign tick_hi = unch ? (tcr_ff.high_clock_select ? edge_det[1] : 1'b1)
                        : tick_lo;

  // chained prescaler: output one tick in the match cycle, then clears
  assign pre_hit = chained && run_all && tick_hi && (ena_lo != ENA_OFF)
                   && (cnt_hi == prd_hi);
  assign pre_nxt = pre_hit ? HALF_ZERO
                 : ((run_all && tick_hi && ena_lo != ENA_OFF) ? cnt_hi + HALF_ONE
                 : cnt_hi);

  assign ok_lo = gcr_ff.extended_feature_enable && (ena_lo == ENA_RELOAD);
  assign ok_hi = gcr_ff.extended_feature_enable && (ena_hi == ENA_RELOAD);

  // ---------------------------------------------------------------
  // counting step
  // ---------------------------------------------------------------
  function automatic step_s step_fn(input logic [CNT_W-1:0] c,
                                    input logic [CNT_W-1:0] p,
                                    input logic [1:0]       ena,
                                    input logic             tick,
                                    input logic             wide);
    step_s            s;
    logic [CNT_W-1:0] inc;
    inc = c + CNT_ONE;
    if (!wide) begin
      inc[CNT_W-1:HALF_W] = HALF_ZERO;
    end
    s.adv  = tick && (ena != ENA_OFF)
             && !((ena == ENA_ONCE) && (c == p))
             && !((c == '0) && (p == '0));
    s.wrap = s.adv && (c == p);
    s.hit  = s.adv && !s.wrap && (inc == p);
    s.nxt  = !s.adv ? c : (s.wrap ? '0 : inc);
    return s;
  endfunction

  // ---------------------------------------------------------------
  // apb access decode
  // ---------------------------------------------------------------
  assign acc     = i_apb.psel && i_apb.penable;
  assign rd_cap  = acc && !pready_ff && !i_apb.pwrite;
  assign wr_done = acc && pready_ff && i_apb.pwrite;
  assign addr_hit = (i_apb.paddr == GLOBAL_CONTROL_OFS) || (i_apb.paddr == TIMER_CONTROL_OFS)
                 || (i_apb.paddr == COUNT_LOW_OFS)  || (i_apb.paddr == COUNT_HIGH_OFS)
                 || (i_apb.paddr == PERIOD_LOW_OFS) || (i_apb.paddr == PERIOD_HIGH_OFS)
                 || (i_apb.paddr == RELOAD_LOW_OFS) || (i_apb.paddr == RELOAD_HIGH_OFS);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_gcr     = gcr_ff;
    nxt_tcr     = tcr_ff;
    nxt_cnt     = cnt_ff;
    nxt_prd     = prd_ff;
    nxt_rel     = rel_ff;
    nxt_shadow  = shadow_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = pslverr_ff;
    nxt_pready  = 1'b0;
    nxt_irq     = 1'b0;
    rld_lo      = 1'b0;
    rld_hi      = 1'b0;
    s64 = step_fn(cnt_ff, prd_ff, ena_lo, tick_lo && run_all, 1'b1);
    slo = step_fn({HALF_ZERO, cnt_lo}, {HALF_ZERO, prd_lo}, ena_lo,
                  chained ? pre_hit : (tick_lo && run_lo), 1'b0);
    shi = step_fn({HALF_ZERO, cnt_hi}, {HALF_ZERO, prd_hi}, ena_hi,
                  tick_hi && run_hi, 1'b0);
    unique case (mode)
      MODE_64: begin
        nxt_cnt = s64.nxt;
        nxt_irq = s64.hit;
        rld_lo  = s64.wrap;
        rld_hi  = s64.wrap;
      end
      MODE_CHAINED: begin
        nxt_cnt = {pre_nxt, slo.nxt[HALF_W-1:0]};
        nxt_irq = slo.hit;
        rld_lo  = slo.wrap;
        rld_hi  = slo.wrap;
      end
      MODE_UNCHAINED: begin
        nxt_cnt = {shi.nxt[HALF_W-1:0], slo.nxt[HALF_W-1:0]};
        nxt_irq = slo.hit || shi.hit;
        rld_lo  = slo.wrap;
        rld_hi  = shi.wrap;
      end
      default: begin
        nxt_cnt = cnt_ff;
      end
    endcase
    if (rld_lo && ok_lo) begin
      nxt_prd[HALF_W-1:0] = rel_ff[HALF_W-1:0];
    end
    if (rld_hi && (unch ? ok_hi : ok_lo)) begin
      nxt_prd[CNT_W-1:HALF_W] = rel_ff[CNT_W-1:HALF_W];
    end
    if (!run_lo) begin
      nxt_cnt[HALF_W-1:0] = HALF_ZERO;
    end
    if (!run_hi) begin
      nxt_cnt[CNT_W-1:HALF_W] = HALF_ZERO;
    end
    // read data is captured in the first access cycle
    if (acc && !pready_ff) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = !addr_hit;
      nxt_prdata  = '0;
      unique case (i_apb.paddr)
        GLOBAL_CONTROL_OFS: nxt_prdata[GCR_W-1:0] = gcr_ff;
        TIMER_CONTROL_OFS:  nxt_prdata[TCR_W-1:0] = tcr_ff;
        COUNT_LOW_OFS:      nxt_prdata = cnt_lo;
        COUNT_HIGH_OFS:     nxt_prdata = is64 ? shadow_ff : cnt_hi;
        PERIOD_LOW_OFS:     nxt_prdata = prd_lo;
        PERIOD_HIGH_OFS:    nxt_prdata = prd_hi;
        RELOAD_LOW_OFS:     nxt_prdata = rel_ff[HALF_W-1:0];
        RELOAD_HIGH_OFS:    nxt_prdata = rel_ff[CNT_W-1:HALF_W];
        default:            nxt_prdata = '0;
      endcase
    end
    if (rd_cap && is64 && (i_apb.paddr == COUNT_LOW_OFS)) begin
      nxt_shadow = cnt_hi;
    end
    // software writes take effect at the completing edge
    if (wr_done && !pslverr_ff) begin
      unique case (i_apb.paddr)
        GLOBAL_CONTROL_OFS: nxt_gcr = global_control_s'(i_apb.pwdata[GCR_W-1:0]);
        TIMER_CONTROL_OFS:  nxt_tcr = timer_control_s'(i_apb.pwdata[TCR_W-1:0]);
        COUNT_LOW_OFS:      nxt_cnt[HALF_W-1:0]     = i_apb.pwdata;
        COUNT_HIGH_OFS:     nxt_cnt[CNT_W-1:HALF_W] = i_apb.pwdata;
        PERIOD_LOW_OFS:     nxt_prd[HALF_W-1:0]     = i_apb.pwdata;
        PERIOD_HIGH_OFS:    nxt_prd[CNT_W-1:HALF_W] = i_apb.pwdata;
        RELOAD_LOW_OFS:     nxt_rel[HALF_W-1:0]     = i_apb.pwdata;
        RELOAD_HIGH_OFS:    nxt_rel[CNT_W-1:HALF_W] = i_apb.pwdata;
        default:            nxt_gcr = gcr_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gcr_ff     <= GCR_RESET;
      tcr_ff     <= TCR_RESET;
      cnt_ff     <= '0;
      prd_ff     <= '0;
      rel_ff     <= '0;
      shadow_ff  <= '0;
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff     <= 1'b0;
    end else if (i_ce) begin
      gcr_ff     <= nxt_gcr;
      tcr_ff     <= nxt_tcr;
      cnt_ff     <= nxt_cnt;
      prd_ff     <= nxt_prd;
      rel_ff     <= nxt_rel;
      shadow_ff  <= nxt_shadow;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff     <= nxt_irq;
    end
  end

  assign o_prdata                = prdata_ff;
  assign o_pready                = pready_ff;
  assign o_pslverr               = pslverr_ff;
  assign o_timer_match_irq       = irq_ff;
  assign o_timer_match_dma_event = irq_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  reload_gate_a: assert property (
    (!gcr_ff.extended_feature_enable && !wr_done) |=> $stable(prd_ff))
    else $error("period changed with extended features off");

  ext_count_a: assert property (
    (i_ce && is64 && run_all && tcr_ff.low_clock_select && ena_lo == ENA_CONT
     && edge_det[0] && cnt_ff != prd_ff && !wr_done)
    |=> cnt_ff == $past(cnt_ff) + CNT_ONE)
    else $error("external edge did not advance counter");

  ext_idle_a: assert property (
    (i_ce && is64 && run_all && tcr_ff.low_clock_select && !edge_det[0] && !wr_done)
    |=> $stable(cnt_ff))
    else $error("counter moved without external edge");

  int_count_a: assert property (
    (i_ce && is64 && run_all && !tcr_ff.low_clock_select && ena_lo != ENA_OFF
     && (ena_lo != ENA_ONCE || cnt_ff + CNT_ONE != prd_ff)
     && cnt_ff != prd_ff && !wr_done) ##1 (i_ce && !wr_done)
    |=> cnt_ff == $past(cnt_ff, 2) + CNT_ONE + CNT_ONE || cnt_ff == '0)
    else $error("internal clock count rate wrong");

  hold_off_a: assert property (
    (is64 && ena_lo == ENA_OFF && run_all && !wr_done) |=> $stable(cnt_ff))
    else $error("disabled counter moved");

  once_stop_a: assert property (
    (is64 && ena_lo == ENA_ONCE && run_all && cnt_ff == prd_ff && !wr_done)
    |=> $stable(cnt_ff) && !o_timer_match_irq)
    else $error("one-shot did not stop at period");

  wrap_zero_a: assert property (
    (i_ce && is64 && s64.wrap && !wr_done) |=> cnt_ff == '0)
    else $error("continuous counter did not clear after match");

  reload_load_a: assert property (
    (i_ce && is64 && s64.wrap && ok_lo && !wr_done) |=> prd_ff == $past(rel_ff))
    else $error("period not reloaded at wrap");

  match_irq_a: assert property (
    (i_ce && is64 && s64.hit && !wr_done)
    |=> o_timer_match_irq && o_timer_match_dma_event && cnt_ff == prd_ff
    ##1 (!$past(i_ce) || !o_timer_match_irq))
    else $error("match event missing");

  run_reset_a: assert property (
    (i_ce && !run_lo && !run_hi && !wr_done) |=> cnt_ff == '0)
    else $error("counter not held in reset");

  zero_stall_a: assert property (
    (cnt_ff == '0 && prd_ff == '0 && !wr_done) |=> cnt_ff == '0)
    else $error("zero period counter advanced");

  shadow_latch_a: assert property (
    (i_ce && rd_cap && is64 && i_apb.paddr == COUNT_LOW_OFS)
    |=> shadow_ff == $past(cnt_hi))
    else $error("shadow not latched on low read");

  shadow_read_a: assert property (
    (i_ce && rd_cap && is64 && i_apb.paddr == COUNT_HIGH_OFS)
    |=> o_pready && o_prdata == $past(shadow_ff))
    else $error("high read did not return shadow");

endmodule

//--- gp_timer_host_model.sv
// partner: apb requester with irq and dma event monitor for the timer core
`timescale 1ns/1ps
module gp_timer_host_model
  import gp_timer_pkg::*;
(
  input  wire logic              i_clk,
  output apb_req_s               o_apb,
  input  wire logic [DATA_W-1:0] i_prdata,
  input  wire logic              i_pready,
  input  wire logic              i_pslverr,
  input  wire logic              i_irq,
  input  wire logic              i_dma
);
  int unsigned cyc;
  int unsigned irq_n;
  int unsigned last_irq;
  int unsigned gap;
  int unsigned dma_bad;

  initial o_apb = '0;

  // ---------------------------------------------------------------
  // event monitor
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (i_dma !== i_irq) dma_bad <= dma_bad + 1;
    if (i_irq === 1'b1) begin
      irq_n    <= irq_n + 1;
      gap      <= cyc - last_irq;
      last_irq <= cyc;
    end
  end

  // ---------------------------------------------------------------
  // one apb transfer; the order of low and high word reads is left to the caller
  // ---------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                      input logic [DATA_W-1:0] wdata,
                      output logic [DATA_W-1:0] rdata, output logic err);
    @(posedge i_clk);
    o_apb.psel    <= 1'b1;
    o_apb.penable <= 1'b0;
    o_apb.pwrite  <= wr;
    o_apb.paddr   <= addr;
    o_apb.pwdata  <= wdata;
    @(posedge i_clk);
    o_apb.penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    rdata = i_prdata;
    err   = i_pslverr;
    o_apb.psel    <= 1'b0;
    o_apb.penable <= 1'b0;
    o_apb.paddr   <= ~addr;
    o_apb.pwdata  <= ~wdata;
  endtask
endmodule

//--- gp_timer_64bit_core_tb.sv
// testbench: self-checking run of the 64-bit timer core
`timescale 1ns/1ps
module gp_timer_64bit_core_tb
  import gp_timer_pkg::*;
;
  logic              i_clk;
  logic              i_rst;
  logic              i_ce;
  logic              low_pin;
  logic              high_pin;
  apb_req_s          apb;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              dma;
  int                fails;
  int                checks_done;
  int                seed = 99;

  gp_timer_64bit_core gp_timer_64bit_core_i (
    .i_clk                   (i_clk),
    .i_rst                   (i_rst),
    .i_ce                    (i_ce),
    .i_apb                   (apb),
    .i_low_ext_input         (low_pin),
    .i_high_ext_input        (high_pin),
    .o_prdata                (prdata),
    .o_pready                (pready),
    .o_pslverr               (pslverr),
    .o_timer_match_irq       (irq),
    .o_timer_match_dma_event (dma)
  );

  gp_timer_host_model gp_timer_host_model_i (
    .i_clk     (i_clk),
    .o_apb     (apb),
    .i_prdata  (prdata),
    .i_pready  (pready),
    .i_pslverr (pslverr),
    .i_irq     (irq),
    .i_dma     (dma)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [DATA_W-1:0] gcr_word(input logic [1:0] runs, input logic [1:0] mode,
                                                 input logic feat);
    return {27'h0, feat, mode, runs};
  endfunction

  function automatic logic [DATA_W-1:0] tcr_word(input logic [1:0] ena, input logic ext);
    return {29'h0, ext, ena};
  endfunction

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    logic              e;
    gp_timer_host_model_i.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                        input string what);
    logic [DATA_W-1:0] r;
    logic              e;
    gp_timer_host_model_i.xfer(1'b0, a, '0, r, e);
    check(r, exp, what);
  endtask

  task automatic arm(input logic [DATA_W-1:0] prd, input logic [DATA_W-1:0] rel,
                     input logic [1:0] ena, input logic feat);
    wr(TIMER_CONTROL_OFS, '0);
    wr(GLOBAL_CONTROL_OFS, gcr_word(2'b11, MODE_64, feat));
    wr(COUNT_LOW_OFS, '0);
    wr(COUNT_HIGH_OFS, '0);
    wr(PERIOD_LOW_OFS, prd);
    wr(PERIOD_HIGH_OFS, '0);
    wr(RELOAD_LOW_OFS, rel);
    wr(RELOAD_HIGH_OFS, '0);
    wr(TIMER_CONTROL_OFS, tcr_word(ena, 1'b0));
  endtask

  task automatic wait_irq(input int n);
    int base;
    base = gp_timer_host_model_i.irq_n;
    for (int k = 0; k < 4000 && gp_timer_host_model_i.irq_n < base + n; k++) @(posedge i_clk);
    check(gp_timer_host_model_i.irq_n >= base + n, 1, "irq count");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    fails++;
    report_and_stop;
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [DATA_W-1:0] p;
    logic [DATA_W-1:0] p2;
    logic [DATA_W-1:0] r;
    logic              e;
    int                base;
    i_rst = 1'b1;
    i_ce = 1'b1;
    low_pin = 1'b0;
    high_pin = 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(GLOBAL_CONTROL_OFS, '0, "gcr reset");
    rd_chk(TIMER_CONTROL_OFS, '0, "tcr reset");
    gp_timer_host_model_i.xfer(1'b0, 8'h20, '0, r, e);
    check(e, 1, "unmapped error");
    wr(GLOBAL_CONTROL_OFS, gcr_word(2'b11, MODE_64, 1'b0));
    wr(COUNT_HIGH_OFS, 32'ha5);
    rd_chk(COUNT_HIGH_OFS, '0, "unpaired high");
    wr(COUNT_LOW_OFS, 32'h11);
    rd_chk(COUNT_LOW_OFS, 32'h11, "low word");
    rd_chk(COUNT_HIGH_OFS, 32'ha5, "shadow high");
    wr(GLOBAL_CONTROL_OFS, gcr_word(2'b00, MODE_64, 1'b0));
    wr(PERIOD_LOW_OFS, 32'h5);
    base = gp_timer_host_model_i.irq_n;
    wr(TIMER_CONTROL_OFS, tcr_word(ENA_CONT, 1'b0));
    repeat (30) @(posedge i_clk);
    rd_chk(COUNT_LOW_OFS, '0, "held in reset");
    check(gp_timer_host_model_i.irq_n, base, "no irq in reset");
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 32'h1 : 32'h4 + ({$random(seed)} % 13);
      arm(p, '0, ENA_CONT, 1'b0);
      wait_irq(3);
      check(gp_timer_host_model_i.gap, p + 1, "continuous gap");
    end
    p = 32'h6 + ({$random(seed)} % 9);
    arm(p, '0, ENA_ONCE, 1'b0);
    wait_irq(1);
    base = gp_timer_host_model_i.irq_n;
    repeat (40) @(posedge i_clk);
    check(gp_timer_host_model_i.irq_n, base, "one shot stops");
    rd_chk(COUNT_LOW_OFS, p, "one shot end");
    arm(32'h1000, '0, ENA_CONT, 1'b0);
    repeat (30) @(posedge i_clk);
    wr(TIMER_CONTROL_OFS, tcr_word(ENA_OFF, 1'b0));
    gp_timer_host_model_i.xfer(1'b0, COUNT_LOW_OFS, '0, r, e);
    wr(TIMER_CONTROL_OFS, 32'h38);
    repeat (20) @(posedge i_clk);
    rd_chk(COUNT_LOW_OFS, r, "held when off");
    p2 = 32'h4 + ({$random(seed)} % 9);
    arm(32'h5, p2, ENA_RELOAD, 1'b1);
    wait_irq(3);
    check(gp_timer_host_model_i.gap, p2 + 1, "reload gap");
    rd_chk(PERIOD_LOW_OFS, p2, "period reloaded");
    arm(32'h5, p2, ENA_RELOAD, 1'b0);
    wait_irq(3);
    check(gp_timer_host_model_i.gap, 32'h6, "reload gated");
    arm('0, '0, ENA_CONT, 1'b0);
    repeat (30) @(posedge i_clk);
    rd_chk(COUNT_LOW_OFS, '0, "zero period");
    wr(TIMER_CONTROL_OFS, '0);
    wr(GLOBAL_CONTROL_OFS, gcr_word(2'b11, MODE_UNCHAINED, 1'b0));
    wr(COUNT_HIGH_OFS, 32'h77);
    rd_chk(COUNT_HIGH_OFS, 32'h77, "live high word");
    wr(GLOBAL_CONTROL_OFS, gcr_word(2'b11, MODE_CHAINED, 1'b0));
    wr(COUNT_HIGH_OFS, '0);
    wr(PERIOD_HIGH_OFS, 32'h1);
    wr(PERIOD_LOW_OFS, p);
    wr(TIMER_CONTROL_OFS, tcr_word(ENA_CONT, 1'b0));
    wait_irq(3);
    check(gp_timer_host_model_i.gap, 2 * (p + 1), "chained gap");
    arm(32'h100, '0, ENA_OFF, 1'b0);
    wr(TIMER_CONTROL_OFS, tcr_word(ENA_CONT, 1'b1));
    repeat (20) @(posedge i_clk);
    rd_chk(COUNT_LOW_OFS, '0, "no internal ticks");
    p = 32'h3 + ({$random(seed)} % 6);
    for (int i = 0; i < p; i++) begin
      @(posedge i_clk);
      low_pin <= 1'b1;
      high_pin <= i[0];
      repeat (3) @(posedge i_clk);
      low_pin <= 1'b0;
      repeat (3) @(posedge i_clk);
      high_pin <= 1'b0;
    end
    repeat (6) @(posedge i_clk);
    rd_chk(COUNT_LOW_OFS, p, "external edges");
    wr(TIMER_CONTROL_OFS, tcr_word(ENA_OFF, 1'b1));
    repeat (8) @(posedge i_clk);
    check(gp_timer_host_model_i.dma_bad, 0, "dma mirrors irq");
    report_and_stop;
  end
endmodule
